// [design/pdcs_regs.sv]
// Purpose : Control and status space of the program and debug link
// Assumes : Decoder hands single-byte direct accesses on the user port
// Notes   : Link clock sampled through two flops, edges found locally
//
// Notes on behaviour
// - Space reached only by control load/store
// - Status bits 7:2 and 0 read zero
// - Key success sets memory enable flag
// - Writing status clears memory enable flag
// - Writing 0x59 to hold register resets core
// - Reset holds until another value written
// - Hold read gives state in bit zero
// - Turnaround field picks idle bits rx-to-tx
// - Reset value gives 128 idle bits
// - Decode 128 down to 2, 11x is 2
// - No guard time from tx to rx
// - Direct, single-byte, address in instruction
// - Pointer register never used here
// - Key reception with key_ok set sets memory enable flag
`timescale 1ns/1ps
`include "pdcs_consts.svh"

module pdcs_regs
  import pdcs_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rstn,
  // Link clock pin
  input  wire logic      link_clk,
  // Access from the instruction decoder
  input  wire logic      req_valid,
  input  wire pdcs_req_t req,
  input  wire logic      key_ok,
  output logic [7:0]     rdata,
  output logic           rdata_valid,
  // Direction change requests
  input  wire logic      want_tx,
  input  wire logic      want_rx,
  // Results
  output logic           tx_enable,
  output logic           guard_busy,
  output logic           mem_enable,
  output logic           core_reset
);

  // ****************************************************************
  // Link clock sampling
  // ****************************************************************
  logic link_s1_q, link_s2_q, link_s3_q;
  logic bit_tick;

  // Two-flop synchroniser plus edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
      link_s3_q <= 1'b0;
    end else begin
      link_s1_q <= link_clk;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
    end
  end

  // One bit time per rising link edge
  assign bit_tick = link_s2_q & ~link_s3_q;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic                   memen_q, memen_d;
  logic                   hold_q, hold_d;
  logic [`PDCS_TURN_W-1:0] turn_q, turn_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   rvalid_q, rvalid_d;
  logic                   is_load, is_store;

  // Only the dedicated load and store reach the space
  assign is_load  = req_valid && (req.op == `PDCS_OP_LOAD);
  assign is_store = req_valid && (req.op == `PDCS_OP_STORE);

  // Next values of the registers
  always_comb begin
    memen_d  = memen_q;
    hold_d   = hold_q;
    turn_d   = turn_q;
    rdata_d  = rdata_q;
    rvalid_d = is_load;
    // Address comes from the instruction, no pointer used
    if (is_store) begin
      unique case (req.addr)
        `PDCS_OFS_STATUS: memen_d = 1'b0;
        `PDCS_OFS_HOLD:   hold_d  = (req.wdata == `PDCS_HOLD_SIG);
        `PDCS_OFS_CTRL:   turn_d  = req.wdata[`PDCS_TURN_W-1:0];
        default:          ;
      endcase
    end
    // Key success wins over a clear in the same cycle
    if (req_valid && req.op == `PDCS_OP_KEY && key_ok) begin
      memen_d = 1'b1;
    end
    if (is_load) begin
      unique case (req.addr)
        `PDCS_OFS_STATUS: rdata_d = {6'h00, memen_q, 1'b0};
        `PDCS_OFS_HOLD:   rdata_d = {7'h00, hold_q};
        `PDCS_OFS_CTRL:   rdata_d = {5'h00, turn_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memen_q  <= 1'b0;
      hold_q   <= 1'b0;
      turn_q   <= `PDCS_TURN_RST;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      memen_q  <= memen_d;
      hold_q   <= hold_d;
      turn_q   <= turn_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata       = rdata_q;
  assign rdata_valid = rvalid_q;
  assign mem_enable  = memen_q;
  assign core_reset  = hold_q;

  // ****************************************************************
  // Turnaround guard
  // ****************************************************************
  pdcs_dir_t  dir_q, dir_d;
  logic [7:0] guard_q, guard_d;
  logic [7:0] guard_len;

  // Idle-bit count from the field
  always_comb begin
    unique case (turn_q)
      3'h0: guard_len = `PDCS_IDLE_C0;
      3'h1: guard_len = `PDCS_IDLE_C1;
      3'h2: guard_len = `PDCS_IDLE_C2;
      3'h3: guard_len = `PDCS_IDLE_C3;
      3'h4: guard_len = `PDCS_IDLE_C4;
      3'h5: guard_len = `PDCS_IDLE_C5;
      3'h6: guard_len = `PDCS_IDLE_C6;
      3'h7: guard_len = `PDCS_IDLE_C7;
    endcase
  end

  // Direction sequencing
  always_comb begin
    dir_d   = dir_q;
    guard_d = guard_q;
    unique case (dir_q)
      PDCS_RX: begin
        if (want_tx) begin
          dir_d   = PDCS_GUARD;
          guard_d = guard_len;
        end
      end
      PDCS_GUARD: begin
        if (bit_tick) begin
          guard_d = guard_q - 8'h01;
          if (guard_q == 8'h01) begin
            dir_d = PDCS_TX;
          end
        end
      end
      PDCS_TX: begin
        if (want_rx) begin
          dir_d = PDCS_RX;
        end
      end
      default: dir_d = PDCS_RX;
    endcase
  end

  // Direction storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_q   <= PDCS_RX;
      guard_q <= 8'h00;
    end else begin
      dir_q   <= dir_d;
      guard_q <= guard_d;
    end
  end

  assign tx_enable  = (dir_q == PDCS_TX);
  assign guard_busy = (dir_q == PDCS_GUARD);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_status_read;
    @(posedge clk) disable iff (!rstn)
      is_load && req.addr == `PDCS_OFS_STATUS |=> rdata == {6'h00, $past(memen_q), 1'b0};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_key_sets;
    @(posedge clk) disable iff (!rstn)
      req_valid && req.op == `PDCS_OP_KEY && key_ok |=> mem_enable;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("key did not set flag");

  property p_status_clear;
    @(posedge clk) disable iff (!rstn)
      is_store && req.addr == `PDCS_OFS_STATUS && !(req.op == `PDCS_OP_KEY) |=> !mem_enable;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("flag not cleared");

  property p_hold_sig;
    @(posedge clk) disable iff (!rstn)
      is_store && req.addr == `PDCS_OFS_HOLD |=>
        core_reset == ($past(req.wdata) == `PDCS_HOLD_SIG);
  endproperty
  a_hold_sig: assert property (p_hold_sig) else $error("hold compare wrong");

  property p_hold_keep;
    @(posedge clk) disable iff (!rstn)
      !(is_store && req.addr == `PDCS_OFS_HOLD) |=> core_reset == $past(core_reset);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold changed unasked");

  property p_hold_read;
    @(posedge clk) disable iff (!rstn)
      is_load && req.addr == `PDCS_OFS_HOLD |=> rdata == {7'h00, $past(hold_q)};
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("hold read wrong");

  property p_guard_load;
    @(posedge clk) disable iff (!rstn)
      dir_q == PDCS_RX && want_tx && turn_q == 3'h7 |=> guard_q == `PDCS_IDLE_C7 && guard_busy;
  endproperty
  a_guard_load: assert property (p_guard_load) else $error("guard count wrong");

  property p_no_tx_guard;
    @(posedge clk) disable iff (!rstn)
      tx_enable && want_rx |=> !tx_enable && !guard_busy;
  endproperty
  a_no_tx_guard: assert property (p_no_tx_guard) else $error("guard on tx to rx");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rstn)
      is_load && req.addr > `PDCS_OFS_CTRL |=> rdata == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved not zero");

  property p_rsvd_store;
    @(posedge clk) disable iff (!rstn)
      is_store && req.addr > `PDCS_OFS_CTRL |=>
        $stable(memen_q) && $stable(hold_q) && $stable(turn_q);
  endproperty
  a_rsvd_store: assert property (p_rsvd_store) else $error("reserved write landed");

  property p_load_valid;
    @(posedge clk) disable iff (!rstn)
      is_load |=> rdata_valid;
  endproperty
  a_load_valid: assert property (p_load_valid) else $error("load not answered");

  property p_no_valid;
    @(posedge clk) disable iff (!rstn)
      !is_load |=> !rdata_valid;
  endproperty
  a_no_valid: assert property (p_no_valid) else $error("answer without load");

  property p_ctrl_write;
    @(posedge clk) disable iff (!rstn)
      is_store && req.addr == `PDCS_OFS_CTRL |=>
        {5'h00, turn_q} == ($past(req.wdata) & 8'h07);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_ctrl_read;
    @(posedge clk) disable iff (!rstn)
      is_load && req.addr == `PDCS_OFS_CTRL |=> rdata == {5'h00, $past(turn_q)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_guard_wait;
    @(posedge clk) disable iff (!rstn)
      guard_busy && !bit_tick |=> guard_busy && $stable(guard_q);
  endproperty
  a_guard_wait: assert property (p_guard_wait) else $error("guard moved without bit");

  property p_guard_end;
    @(posedge clk) disable iff (!rstn)
      guard_busy && bit_tick && guard_q == 8'h01 |=> tx_enable;
  endproperty
  a_guard_end: assert property (p_guard_end) else $error("guard did not end");

  property p_guard_max;
    @(posedge clk) disable iff (!rstn)
      dir_q == PDCS_RX && want_tx && turn_q == 3'h0 |=> guard_q == `PDCS_IDLE_C0;
  endproperty
  a_guard_max: assert property (p_guard_max) else $error("default guard wrong");

  c_key:   cover property (@(posedge clk) disable iff (!rstn) $rose(mem_enable));
  c_hold:  cover property (@(posedge clk) disable iff (!rstn) $rose(core_reset));
  c_guard: cover property (@(posedge clk) disable iff (!rstn) guard_busy ##1 tx_enable);
  c_clear: cover property (@(posedge clk) disable iff (!rstn) $fell(mem_enable));
  c_back:  cover property (@(posedge clk) disable iff (!rstn) $fell(tx_enable));

endmodule

// [design/pdcs_consts.svh]
// Purpose : Offsets, fields, reset values and timing for the control space
// Assumes : Included by the design module and the bench
// Notes   : Definitions only
`ifndef PDCS_CONSTS_SVH
`define PDCS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PDCS_OFS_STATUS     4'h0
`define PDCS_OFS_HOLD       4'h1
`define PDCS_OFS_CTRL       4'h2

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PDCS_MEMEN_BIT      1
`define PDCS_HOLD_SIG       8'h59
`define PDCS_TURN_W         3
`define PDCS_TURN_RST       3'h0

// ****************************************************************
// Idle bits per turnaround code
// ****************************************************************
`define PDCS_IDLE_C0        8'h80
`define PDCS_IDLE_C1        8'h40
`define PDCS_IDLE_C2        8'h20
`define PDCS_IDLE_C3        8'h10
`define PDCS_IDLE_C4        8'h08
`define PDCS_IDLE_C5        8'h04
`define PDCS_IDLE_C6        8'h02
`define PDCS_IDLE_C7        8'h02

// ****************************************************************
// Instruction codes on the user port
// ****************************************************************
`define PDCS_OP_LOAD        2'h1
`define PDCS_OP_STORE       2'h2
`define PDCS_OP_KEY         2'h3

`endif

// [design/pdcs_pkg.sv]
// Purpose : Types for the control and status space
// Assumes : pdcs_consts.svh defines the numbers
// Notes   : Types only
package pdcs_pkg;

  // ****************************************************************
  // Access request from the instruction decoder
  // ****************************************************************
  typedef struct packed {
    logic [1:0] op;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pdcs_req_t;

  // ****************************************************************
  // Direction state of the link
  // ****************************************************************
  typedef enum logic [1:0] {
    PDCS_RX    = 2'b00,
    PDCS_GUARD = 2'b01,
    PDCS_TX    = 2'b10
  } pdcs_dir_t;

endpackage

// [test/pdcs_link_model.sv]
// Purpose : Far side of the link, the programmer's bit clock
// Assumes : Programmer runs the clock only while a frame is active
// Notes   : Idle level low between frames, 80 ns bit period
`timescale 1ns/1ps

module pdcs_link_model (
  // Frame control from the bench
  input  wire logic run,
  // Link clock pin
  output logic      link_clk
);
  // ****************************************************************
  // Bit clock generation
  // ****************************************************************
  initial link_clk = 1'b0;

  // Toggle while a frame runs, park low otherwise
  always begin
    #40;
    link_clk = run ? ~link_clk : 1'b0;
  end
endmodule

// [test/tb.sv]
// Purpose : Self-checking bench for the control and status space
// Assumes : One-cycle load answer, guard counted on link clock rises
// Notes   : All eight turnaround codes walked, reset value first
`timescale 1ns/1ps
`include "pdcs_consts.svh"

module tb;
  import pdcs_pkg::*;

  `define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

  logic       clk, rstn, req_valid, key_ok, want_tx, want_rx, run;
  logic       link_clk, tx_enable, guard_busy, mem_enable, core_reset, rdata_valid;
  logic [7:0] rdata;
  pdcs_req_t  req;
  int         err_count, num_checks, rise_cnt, n;

  // ****************************************************************
  // Instances
  // ****************************************************************
  pdcs_regs pdcs_regs_i (.clk(clk), .rstn(rstn), .link_clk(link_clk),
    .req_valid(req_valid), .req(req), .key_ok(key_ok), .rdata(rdata),
    .rdata_valid(rdata_valid), .want_tx(want_tx), .want_rx(want_rx),
    .tx_enable(tx_enable), .guard_busy(guard_busy), .mem_enable(mem_enable),
    .core_reset(core_reset));
  pdcs_link_model pdcs_link_model_i (.run(run), .link_clk(link_clk));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Link clock rises seen during a guard
  always @(posedge link_clk) rise_cnt++;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One single-byte access, direct address in the request
  task automatic acc(input logic [1:0] op, input logic [3:0] a, input logic [7:0] d,
                     input logic k);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op: op, addr: a, wdata: d};
    key_ok    <= k;
    @(posedge clk);
    req_valid <= 1'b0;
    key_ok    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    acc(`PDCS_OP_LOAD, a, 8'h00, 1'b0);
    `CHK("rdata_valid", 1'b1, rdata_valid)
    `CHK("rdata", ex, rdata)
  endtask

  // Watchdog
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0; req_valid = 1'b0; key_ok = 1'b0; want_tx = 1'b0; want_rx = 1'b0;
    run = 1'b0; req = '0; err_count = 0; num_checks = 0; rise_cnt = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // Reset values
    rd(`PDCS_OFS_STATUS, 8'h00);
    rd(`PDCS_OFS_HOLD, 8'h00);
    rd(`PDCS_OFS_CTRL, 8'h00);
    // Key success then poll the flag
    acc(`PDCS_OP_KEY, 4'h0, 8'h00, 1'b1);
    `CHK("mem_enable", 1'b1, mem_enable)
    rd(`PDCS_OFS_STATUS, 8'h02);
    acc(`PDCS_OP_KEY, 4'h0, 8'h00, 1'b0);
    `CHK("mem_enable", 1'b1, mem_enable)
    acc(`PDCS_OP_STORE, `PDCS_OFS_STATUS, 8'h00, 1'b0);
    `CHK("mem_enable", 1'b0, mem_enable)
    // Hold signature, then a near miss releases
    acc(`PDCS_OP_STORE, `PDCS_OFS_HOLD, 8'h59, 1'b0);
    `CHK("core_reset", 1'b1, core_reset)
    rd(`PDCS_OFS_HOLD, 8'h01);
    acc(`PDCS_OP_STORE, `PDCS_OFS_HOLD, 8'hD9, 1'b0);
    `CHK("core_reset", 1'b0, core_reset)
    // Reserved offset, then an unused op code
    acc(`PDCS_OP_STORE, 4'h5, 8'hFF, 1'b0);
    `CHK("rdata_valid", 1'b0, rdata_valid)
    rd(4'h5, 8'h00);
    acc(2'h0, `PDCS_OFS_CTRL, 8'h07, 1'b0);
    rd(`PDCS_OFS_CTRL, 8'h00);
    // Every turnaround code, reset value first
    for (int c = 0; c < 8; c++) begin
      n = (c >= 6) ? 2 : (128 >> c);
      if (c > 0) acc(`PDCS_OP_STORE, `PDCS_OFS_CTRL, {5'h00, c[2:0]}, 1'b0);
      rd(`PDCS_OFS_CTRL, {5'h00, c[2:0]});
      @(posedge clk);
      want_tx <= 1'b1;
      @(posedge clk);
      want_tx <= 1'b0;
      #1;
      `CHK("guard_busy", 1'b1, guard_busy)
      rise_cnt = 0;
      run = 1'b1;
      for (int w = 0; w < 3000 && tx_enable !== 1'b1; w++) begin
        @(posedge clk);
        #1;
      end
      run = 1'b0;
      `CHK("tx_enable", 1'b1, tx_enable)
      `CHK("guard_bits", n, rise_cnt)
      @(posedge clk);
      want_rx <= 1'b1;
      @(posedge clk);
      want_rx <= 1'b0;
      #1;
      `CHK("tx_enable", 1'b0, tx_enable)
      `CHK("guard_busy", 1'b0, guard_busy)
    end
    // Mid-run reset restores the 128-bit field and drops the hold
    acc(`PDCS_OP_STORE, `PDCS_OFS_HOLD, `PDCS_HOLD_SIG, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK("core_reset", 1'b0, core_reset)
    `CHK("mem_enable", 1'b0, mem_enable)
    rd(`PDCS_OFS_CTRL, 8'h00);
    end_of_test();
  end
endmodule
